//--- osc_trim_map.vh
`ifndef OSC_TRIM_MAP_VH
`define OSC_TRIM_MAP_VH
`define ADDR_LOAD_TRIM      12'h000
`define ADDR_READY_THRESH   12'h004
`define ADDR_TRIM_CTRL      12'h008
`define ADDR_STARTUP_CAP    12'h00C
`define ADDR_STATUS         12'h010
`define ADDR_IRQ_STATUS     12'h014
`define ADDR_IRQ_MASK       12'h018
`define ADDR_REF_TARGET     12'h01C
`define ADDR_REF_SELECT     12'h020
`define ADDR_RESULT_HIGH    12'h024
`define ADDR_RESULT_LOW     12'h028
`define ADDR_GP_DATA        12'h02C
`define RST_LOAD_TRIM       8'h80
`define RST_READY_THRESH    16'h0100
`define RST_COUNT_LIMIT     16'h0080
`define RST_SETTLE_N        8'h08
`define RST_REF_TARGET      32'h00000400
`define POS_TRIM_SELECT     0
`define POS_SETTLE_N        8
`define POS_COUNT_LIMIT     16
`define POS_REF_START       4
`define SEL_SLOW_RC         2'h0
`define SEL_FAST_RC         2'h1
`define SEL_SLOW_XTAL       2'h2
`define SEL_ENH_RC          2'h3
`define IRQ_READY           0
`define IRQ_SETTLE          1
`define IRQ_CAL_DONE        2
`endif

//--- trim_decoder.v
`timescale 1ns/1ps
module trim_decoder (
    input  wire [7:0] crystal_trim_code,
    output wire [4:0] binary_caps,
    output wire [6:0] thermo_caps
);
    assign binary_caps = crystal_trim_code[4:0];
    genvar i;
    generate
        for (i = 0; i < 7; i = i + 1) begin : g_thermo
            assign thermo_caps[i] = (crystal_trim_code[7:5] > i);
        end
    endgenerate
endmodule // trim_decoder

//--- osc_trim_calibration.v
// Summary of operation
// - Eight-bit trim, 0x00 minimum, 0xFF maximum capacitance.
// - One trim code drives both capacitor banks.
// - Low five bits drive binary capacitors directly.
// - Upper three bits thermometer decoded, seven outputs.
// - Ready interrupt when counter equals threshold.
// - Counter ticks fast RC or low-power clock.
// - Hardware enables crystal and applies trim.
// - Trim at limit minus one or current drop.
// - Current mode captures counter when trim applied.
// - Settle ready flag at settle threshold.
// - Slow RC runs 512 kHz during start-up.
// - Fast RC clocks system while crystal settles.
// - Reference counter measures selected oscillator at 16 MHz.
// - Measurement spans programmed measured-clock cycle count.
// - Start bit self-clears; 32-bit result split high/low.
`timescale 1ns/1ps
`include "osc_trim_map.vh"
module osc_trim_calibration (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        startup_request,
    input  wire        wake_not_power_up,
    input  wire        fast_rc_clk,
    input  wire        low_power_clk,
    input  wire        current_drop,
    input  wire        ref_clk_16m,
    input  wire        slow_rc_clk,
    input  wire        slow_xtal_clk,
    input  wire        enh_rc_clk,
    output reg         crystal_enable,
    output reg  [7:0]  crystal_trim_code,
    output wire [4:0]  bank_a_binary,
    output wire [6:0]  bank_a_thermo,
    output wire [4:0]  bank_b_binary,
    output wire [6:0]  bank_b_thermo,
    output reg         slow_rc_fast_mode,
    output reg         sys_clk_from_fast_rc,
    output wire        crystal_ready_irq,
    output wire        irq
);
    localparam ST_IDLE    = 3'b001;
    localparam ST_STARTUP = 3'b010;
    localparam ST_SETTLE  = 3'b100;

    reg [2:0]  state;
    reg [7:0]  crystal_load_trim;
    reg [15:0] ready_threshold_register;
    reg        trim_trigger_select;
    reg [7:0]  settle_threshold;
    reg [15:0] startup_count_limit;
    reg [15:0] startup_capture_register;
    reg [31:0] reference_count_target;
    reg [1:0]  ref_select;
    reg        ref_start;
    reg [31:0] calibration_result;
    reg [7:0]  general_purpose_data_register;
    reg [2:0]  irq_status;
    reg [2:0]  irq_mask;
    reg [15:0] startup_counter;
    reg [7:0]  settle_counter;
    reg        trim_applied_flag;
    reg        settle_ready_flag;
    reg        ready_seen;
    reg [31:0] ref_count;
    reg [31:0] meas_count;
    reg        meas_run;

    // Synchronisers for pins and foreign clocks.
    reg [1:0] s_req, s_wake, s_drop, s_frc, s_lpc, s_ref, s_srcrc, s_sxt, s_erc;
    reg [2:0] e_tick, e_ref, e_src;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_req <= 2'h0;
            s_wake <= 2'h0;
            s_drop <= 2'h0;
            s_frc <= 2'h0;
            s_lpc <= 2'h0;
            s_ref <= 2'h0;
            s_srcrc <= 2'h0;
            s_sxt <= 2'h0;
            s_erc <= 2'h0;
        end else begin
            s_req  <= {s_req[0], startup_request};
            s_wake <= {s_wake[0], wake_not_power_up};
            s_drop <= {s_drop[0], current_drop};
            s_frc  <= {s_frc[0], fast_rc_clk};
            s_lpc  <= {s_lpc[0], low_power_clk};
            s_ref  <= {s_ref[0], ref_clk_16m};
            s_srcrc <= {s_srcrc[0], slow_rc_clk};
            s_sxt  <= {s_sxt[0], slow_xtal_clk};
            s_erc  <= {s_erc[0], enh_rc_clk};
        end
    end

    function meas_select;
        input [1:0] sel;
        input a, b, c, d;
        begin
            case (sel)
                `SEL_SLOW_RC:   meas_select = a;
                `SEL_FAST_RC:   meas_select = b;
                `SEL_SLOW_XTAL: meas_select = c;
                default:        meas_select = d;
            endcase
        end
    endfunction

    wire tick_lvl = s_wake[1] ? s_lpc[1] : s_frc[1];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            e_tick <= 3'h0;
            e_ref <= 3'h0;
            e_src <= 3'h0;
        end else begin
            e_tick <= {e_tick[1:0], tick_lvl};
            e_ref  <= {e_ref[1:0], s_ref[1]};
            e_src  <= {e_src[1:0], meas_select(ref_select, s_srcrc[1], s_frc[1],
                                               s_sxt[1], s_erc[1])};
        end
    end
    wire tick     = e_tick[1] & ~e_tick[2];
    wire ref_edge = e_ref[1] & ~e_ref[2];
    wire src_edge = e_src[1] & ~e_src[2];
    wire req_rise;
    reg  req_d;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) req_d <= 1'b0;
        else req_d <= s_req[1];
    end
    assign req_rise = s_req[1] & ~req_d;

    wire apply_trim = (state == ST_STARTUP) &&
        (trim_trigger_select ? s_drop[1] :
         (startup_counter == startup_count_limit - 16'h0001));
    wire ready_hit  = tick && !ready_seen && (state != ST_IDLE) &&
        (startup_counter + 16'h0001 == ready_threshold_register);
    wire settle_hit = (state == ST_SETTLE) && tick && !settle_ready_flag &&
        (settle_counter + 8'h01 == settle_threshold);
    reg  cal_done;

    // Start-up sequencer.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            crystal_enable <= 1'b0;
            crystal_trim_code <= 8'h00;
            startup_counter <= 16'h0000;
            settle_counter <= 8'h00;
            trim_applied_flag <= 1'b0;
            settle_ready_flag <= 1'b0;
            ready_seen <= 1'b0;
            startup_capture_register <= 16'h0000;
            slow_rc_fast_mode <= 1'b0;
            sys_clk_from_fast_rc <= 1'b0;
        end else begin
            if (req_rise) begin
                state <= ST_STARTUP;
                crystal_enable <= 1'b1;
                startup_counter <= 16'h0000;
                settle_counter <= 8'h00;
                trim_applied_flag <= 1'b0;
                settle_ready_flag <= 1'b0;
                ready_seen <= 1'b0;
                slow_rc_fast_mode <= 1'b1;
                sys_clk_from_fast_rc <= 1'b1;
            end else begin
                if (tick && state != ST_IDLE)
                    startup_counter <= startup_counter + 16'h0001;
                if (ready_hit)
                    ready_seen <= 1'b1;
                case (state)
                    ST_IDLE: begin
                    end
                    ST_STARTUP: begin
                        if (apply_trim) begin
                            crystal_trim_code <= crystal_load_trim;
                            trim_applied_flag <= 1'b1;
                            if (trim_trigger_select)
                                startup_capture_register <= startup_counter;
                            slow_rc_fast_mode <= 1'b0;
                            state <= ST_SETTLE;
                        end
                    end
                    ST_SETTLE: begin
                        if (tick && !settle_ready_flag)
                            settle_counter <= settle_counter + 8'h01;
                        if (settle_hit)
                            settle_ready_flag <= 1'b1;
                        if (ready_hit || ready_seen) begin
                            sys_clk_from_fast_rc <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // Both banks share one decoder output.
    trim_decoder u_dec (
        .crystal_trim_code (crystal_trim_code),
        .binary_caps       (bank_a_binary),
        .thermo_caps       (bank_a_thermo)
    );
    assign bank_b_binary = bank_a_binary;
    assign bank_b_thermo = bank_a_thermo;

    // Reference counter.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_count <= 32'h00000000;
            meas_count <= 32'h00000000;
            meas_run <= 1'b0;
            calibration_result <= 32'h00000000;
            cal_done <= 1'b0;
        end else begin
            cal_done <= 1'b0;
            if (ref_start) begin
                if (src_edge)
                    meas_run <= 1'b1;
                if (ref_edge && meas_run)
                    ref_count <= ref_count + 32'h00000001;
                if (src_edge && meas_run) begin
                    meas_count <= meas_count + 32'h00000001;
                    if (meas_count + 32'h00000001 == reference_count_target) begin
                        calibration_result <= ref_count;
                        cal_done <= 1'b1;
                    end
                end
            end else begin
                ref_count <= 32'h00000000;
                meas_count <= 32'h00000000;
                meas_run <= 1'b0;
            end
        end
    end

    // APB register file.
    wire wr = psel & penable & pwrite;
    wire rd_ok = decode_ok(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~rd_ok;

    function decode_ok;
        input [11:0] a;
        begin
            decode_ok = (a[1:0] == 2'h0) && (a <= `ADDR_GP_DATA);
        end
    endfunction

    wire [2:0] irq_events = {cal_done, settle_hit, ready_hit};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crystal_load_trim <= `RST_LOAD_TRIM;
            ready_threshold_register <= `RST_READY_THRESH;
            trim_trigger_select <= 1'b0;
            settle_threshold <= `RST_SETTLE_N;
            startup_count_limit <= `RST_COUNT_LIMIT;
            reference_count_target <= `RST_REF_TARGET;
            ref_select <= `SEL_SLOW_RC;
            ref_start <= 1'b0;
            general_purpose_data_register <= 8'h00;
            irq_status <= 3'h0;
            irq_mask <= 3'h0;
        end else begin
            if (wr && paddr == `ADDR_LOAD_TRIM)
                crystal_load_trim <= pwdata[7:0];
            if (wr && paddr == `ADDR_READY_THRESH)
                ready_threshold_register <= pwdata[15:0];
            if (wr && paddr == `ADDR_TRIM_CTRL) begin
                trim_trigger_select <= pwdata[`POS_TRIM_SELECT];
                settle_threshold <= pwdata[`POS_SETTLE_N +: 8];
                startup_count_limit <= pwdata[`POS_COUNT_LIMIT +: 16];
            end
            if (wr && paddr == `ADDR_REF_TARGET)
                reference_count_target <= pwdata;
            if (cal_done)
                ref_start <= 1'b0;
            if (wr && paddr == `ADDR_REF_SELECT) begin
                ref_select <= pwdata[1:0];
                if (pwdata[`POS_REF_START])
                    ref_start <= 1'b1;
            end
            if (wr && paddr == `ADDR_GP_DATA)
                general_purpose_data_register <= pwdata[7:0];
            if (wr && paddr == `ADDR_IRQ_MASK)
                irq_mask <= pwdata[2:0];
            irq_status <= (irq_status & ~((wr && paddr == `ADDR_IRQ_STATUS) ?
                           pwdata[2:0] : 3'h0)) | irq_events;
        end
    end

    assign irq = |(irq_status & irq_mask);
    assign crystal_ready_irq = irq_status[`IRQ_READY];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `ADDR_LOAD_TRIM:    prdata <= {24'h000000, crystal_load_trim};
                `ADDR_READY_THRESH: prdata <= {16'h0000, ready_threshold_register};
                `ADDR_TRIM_CTRL:    prdata <= {startup_count_limit, settle_threshold,
                                               7'h00, trim_trigger_select};
                `ADDR_STARTUP_CAP:  prdata <= {16'h0000, startup_capture_register};
                `ADDR_STATUS:       prdata <= {24'h000000, 1'b0,
                                               1'b0, state, crystal_enable,
                                               settle_ready_flag, trim_applied_flag};
                `ADDR_IRQ_STATUS:   prdata <= {29'h00000000, irq_status};
                `ADDR_IRQ_MASK:     prdata <= {29'h00000000, irq_mask};
                `ADDR_REF_TARGET:   prdata <= reference_count_target;
                `ADDR_REF_SELECT:   prdata <= {27'h0000000, ref_start, 2'h0, ref_select};
                `ADDR_RESULT_HIGH:  prdata <= {16'h0000, calibration_result[31:16]};
                `ADDR_RESULT_LOW:   prdata <= {16'h0000, calibration_result[15:0]};
                `ADDR_GP_DATA:      prdata <= {24'h000000, general_purpose_data_register};
                default:            prdata <= 32'h00000000;
            endcase
        end
    end
endmodule // osc_trim_calibration

//--- osc_trim_checker.sv
`timescale 1ns/1ps
module osc_trim_checker (
    input wire       pclk,
    input wire       presetn,
    input wire       startup_request,
    input wire       crystal_enable,
    input wire [7:0] crystal_trim_code,
    input wire [4:0] bank_a_binary,
    input wire [6:0] bank_a_thermo,
    input wire [4:0] bank_b_binary,
    input wire [6:0] bank_b_thermo,
    input wire       slow_rc_fast_mode,
    input wire       sys_clk_from_fast_rc,
    input wire       crystal_ready_irq,
    input wire       irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    banks_equal_a: assert property (
        {bank_a_binary, bank_a_thermo} == {bank_b_binary, bank_b_thermo})
        else $error("capacitor banks differ");
    binary_bits_a: assert property (bank_a_binary == crystal_trim_code[4:0])
        else $error("binary capacitors wrong");
    thermo_bits_a: assert property (
        bank_a_thermo == (7'h7F >> (3'h7 - crystal_trim_code[7:5])))
        else $error("thermometer capacitors wrong");
    enable_start_a: assert property ($rose(startup_request) |-> ##[1:8] crystal_enable)
        else $error("crystal not enabled");
    fast_mode_start_a: assert property (
        $rose(startup_request) |-> ##[1:8] slow_rc_fast_mode)
        else $error("slow rc not sped up");
    rc_clock_start_a: assert property (
        $rose(startup_request) |-> ##[1:8] sys_clk_from_fast_rc)
        else $error("system not on fast rc");
    fast_mode_enable_a: assert property (slow_rc_fast_mode |-> crystal_enable)
        else $error("fast mode without crystal");
    ready_switch_a: assert property (
        $fell(sys_clk_from_fast_rc) |-> ##[0:2] crystal_ready_irq)
        else $error("ready flag missing at switch");
    trim_apply_a: assert property (
        $changed(crystal_trim_code) |-> ##[0:1] !slow_rc_fast_mode)
        else $error("trim applied outside end of start-up");
    cover property ($fell(slow_rc_fast_mode));
    cover property ($rose(crystal_ready_irq));
    cover property ($rose(irq));
endmodule // osc_trim_checker

bind osc_trim_calibration osc_trim_checker i_chk (
    .pclk(pclk), .presetn(presetn), .startup_request(startup_request),
    .crystal_enable(crystal_enable), .crystal_trim_code(crystal_trim_code),
    .bank_a_binary(bank_a_binary), .bank_a_thermo(bank_a_thermo),
    .bank_b_binary(bank_b_binary), .bank_b_thermo(bank_b_thermo),
    .slow_rc_fast_mode(slow_rc_fast_mode), .sys_clk_from_fast_rc(sys_clk_from_fast_rc),
    .crystal_ready_irq(crystal_ready_irq), .irq(irq));

//--- osc_cells_model.sv
`timescale 1ns/1ps
module osc_cells_model #(
    parameter real FRC = 40.0, LPC = 56.0, REF = 20.0, DROP = 1200.0,
    parameter real SRC = 200.0, SXT = 320.0, ERC = 240.0
) (
    input  wire  drop_en,
    output logic fast_rc_clk,
    output logic low_power_clk,
    output logic ref_clk_16m,
    output logic slow_rc_clk,
    output logic slow_xtal_clk,
    output logic enh_rc_clk,
    output logic current_drop
);
    initial begin
        {fast_rc_clk, low_power_clk, ref_clk_16m, current_drop} = 4'h0;
        {slow_rc_clk, slow_xtal_clk, enh_rc_clk} = 3'h0;
    end
    // Start-up counter clocks for power-up and wake-up.
    always #(FRC / 2.0) fast_rc_clk = ~fast_rc_clk;
    always #(LPC / 2.0) low_power_clk = ~low_power_clk;
    // Reference and measured oscillators run free.
    always #(REF / 2.0) ref_clk_16m = ~ref_clk_16m;
    always #(SRC / 2.0) slow_rc_clk = ~slow_rc_clk;
    always #(SXT / 2.0) slow_xtal_clk = ~slow_xtal_clk;
    always #(ERC / 2.0) enh_rc_clk = ~enh_rc_clk;
    // Core current falls a fixed time after the crystal is started.
    always @(posedge drop_en) begin
        #(DROP);
        current_drop = drop_en;
    end
    always @(negedge drop_en) current_drop = 1'b0;
endmodule // osc_cells_model

//--- test_oscillator_trim_and_calibration.sv
`timescale 1ns/1ps
`include "osc_trim_map.vh"
module test_oscillator_trim_and_calibration;
    localparam real FRC = 40.0, LPC = 56.0, REF = 20.0, DROP = 1200.0;
    localparam real SRC = 200.0, SXT = 320.0, ERC = 240.0;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        startup_request, wake_not_power_up, drop_en, current_drop;
    logic        fast_rc_clk, low_power_clk, ref_clk_16m, slow_rc_clk, slow_xtal_clk, enh_rc_clk;
    logic        crystal_enable, slow_rc_fast_mode, sys_clk_from_fast_rc, crystal_ready_irq, irq;
    logic [7:0]  crystal_trim_code;
    logic [4:0]  bank_a_binary, bank_b_binary;
    logic [6:0]  bank_a_thermo, bank_b_thermo;
    int          fails, samples_checked;

    osc_trim_calibration i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .startup_request(startup_request), .wake_not_power_up(wake_not_power_up),
        .fast_rc_clk(fast_rc_clk), .low_power_clk(low_power_clk), .current_drop(current_drop),
        .ref_clk_16m(ref_clk_16m), .slow_rc_clk(slow_rc_clk), .slow_xtal_clk(slow_xtal_clk),
        .enh_rc_clk(enh_rc_clk), .crystal_enable(crystal_enable),
        .crystal_trim_code(crystal_trim_code), .bank_a_binary(bank_a_binary),
        .bank_a_thermo(bank_a_thermo), .bank_b_binary(bank_b_binary),
        .bank_b_thermo(bank_b_thermo), .slow_rc_fast_mode(slow_rc_fast_mode),
        .sys_clk_from_fast_rc(sys_clk_from_fast_rc), .crystal_ready_irq(crystal_ready_irq),
        .irq(irq));
    osc_cells_model #(.FRC(FRC), .LPC(LPC), .REF(REF), .DROP(DROP), .SRC(SRC), .SXT(SXT),
                      .ERC(ERC)) i_cells (
        .drop_en(drop_en), .fast_rc_clk(fast_rc_clk), .low_power_clk(low_power_clk),
        .ref_clk_16m(ref_clk_16m), .slow_rc_clk(slow_rc_clk), .slow_xtal_clk(slow_xtal_clk),
        .enh_rc_clk(enh_rc_clk), .current_drop(current_drop));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial begin
        #100000;
        fails++;
        summarize;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] near(input logic [31:0] got, input real exp);
        return {31'h0, got >= exp - 3.0 && got <= exp + 3.0};
    endfunction

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(rdat, exp);
    endtask

    task automatic t_regs;
        rdchk(`ADDR_LOAD_TRIM, {24'h0, `RST_LOAD_TRIM});
        rdchk(`ADDR_READY_THRESH, {16'h0, `RST_READY_THRESH});
        rdchk(`ADDR_TRIM_CTRL, {`RST_COUNT_LIMIT, `RST_SETTLE_N, 8'h00});
        rdchk(`ADDR_REF_TARGET, `RST_REF_TARGET);
        apb(1'b1, `ADDR_STARTUP_CAP, 32'hFFFF_FFFF);
        rdchk(`ADDR_STARTUP_CAP, 32'h0);
        rdchk(12'h030, 32'h0);
        chk(perr, 1'b1);
        apb(1'b1, `ADDR_LOAD_TRIM, 32'h5A);
        rdchk(`ADDR_LOAD_TRIM, 32'h5A);
        apb(1'b1, `ADDR_GP_DATA, 32'h20);
        rdchk(`ADDR_GP_DATA, 32'h20);
        apb(1'b1, `ADDR_GP_DATA, 32'h40);
        rdchk(`ADDR_GP_DATA, 32'h40);
    endtask

    task automatic t_startup(input logic wake, input logic cur, input logic [7:0] code,
                             input logic unmask);
        realtime t0;
        real     per;
        int      n;
        per = wake ? LPC : FRC;
        apb(1'b1, `ADDR_LOAD_TRIM, {24'h0, code});
        apb(1'b1, `ADDR_TRIM_CTRL, {16'h0010, 8'h04, 7'h00, cur});
        apb(1'b1, `ADDR_READY_THRESH, 32'h28);
        apb(1'b1, `ADDR_IRQ_MASK, {31'h0, unmask});
        wake_not_power_up <= wake;
        drop_en <= cur;
        startup_request <= 1'b1;
        for (n = 0; n < 50 && slow_rc_fast_mode !== 1'b1; n++) @(posedge pclk);
        t0 = $realtime;
        chk({crystal_enable, sys_clk_from_fast_rc}, 2'h3);
        for (n = 0; n < 3000 && slow_rc_fast_mode !== 1'b0; n++) @(posedge pclk);
        chk(crystal_trim_code, code);
        chk({bank_a_binary, bank_b_binary}, {code[4:0], code[4:0]});
        chk({bank_a_thermo, bank_b_thermo}, {2{7'h7F >> (3'h7 - code[7:5])}});
        if (cur) begin
            apb(1'b0, `ADDR_STARTUP_CAP, 32'h0);
            chk(near(rdat, DROP / per), 1'b1);
        end else chk(near($rtoi(($realtime - t0) / per), 15.0), 1'b1);
        for (n = 0; n < 3000 && crystal_ready_irq !== 1'b1; n++) @(posedge pclk);
        chk(near($rtoi(($realtime - t0) / per), 40.0), 1'b1);
        repeat (2) @(posedge pclk);
        chk({sys_clk_from_fast_rc, irq}, {1'b0, unmask});
        rdchk(`ADDR_STATUS, 32'h0000000F);
        apb(1'b1, `ADDR_IRQ_STATUS, 32'h7);
        chk({crystal_ready_irq, irq}, 2'h0);
        startup_request <= 1'b0;
        drop_en <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic t_cal(input logic [1:0] sel, input real per);
        logic [15:0] high;
        int          n;
        apb(1'b1, `ADDR_REF_TARGET, 32'h8);
        apb(1'b1, `ADDR_REF_SELECT, {27'h0, 1'b1, 2'h0, sel});
        for (n = 0; n < 400 && (n == 0 || rdat[4] === 1'b1); n++) apb(1'b0, `ADDR_REF_SELECT, 32'h0);
        chk(rdat[4], 1'b0);
        apb(1'b0, `ADDR_RESULT_HIGH, 32'h0);
        high = rdat[15:0];
        apb(1'b0, `ADDR_RESULT_LOW, 32'h0);
        chk(near({high, rdat[15:0]}, 8.0 * per / REF), 1'b1);
        apb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
        chk(rdat[2], 1'b1);
        apb(1'b1, `ADDR_IRQ_STATUS, 32'h4);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, startup_request, wake_not_power_up, drop_en} = 7'h0;
        {paddr, pwdata} = 44'h0;
        fails = 0;
        samples_checked = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_startup(1'b0, 1'b0, 8'hA5, 1'b1);
        t_startup(1'b1, 1'b1, 8'h1F, 1'b0);
        t_startup(1'b1, 1'b0, 8'h00, 1'b1);
        t_startup(1'b0, 1'b1, 8'hFF, 1'b1);
        t_cal(`SEL_SLOW_RC, SRC);
        t_cal(`SEL_FAST_RC, FRC);
        t_cal(`SEL_SLOW_XTAL, SXT);
        t_cal(`SEL_ENH_RC, ERC);
        summarize;
    end
endmodule // test_oscillator_trim_and_calibration
